// ### core/pesc_defines.svh
// Register indices, field positions, reset values and limits of the event status block
`ifndef PESC_DEFINES_SVH
`define PESC_DEFINES_SVH

`define PESC_ADR_W        8
`define PESC_IDX_W        6
`define PESC_IDX_CTRL     6'h11
`define PESC_IDX_STAT2    6'h13
`define PESC_IDX_FCC      6'h14
`define PESC_IDX_REC      6'h15

`define PESC_CTRL_OUT_EN  0
`define PESC_CTRL_INT_EN  1
`define PESC_CTRL_TEST    2
`define PESC_CTRL_POL     3
`define PESC_CTRL_FC_EN   4
`define PESC_CTRL_RE_EN   5
`define PESC_CTRL_FC_HF   8
`define PESC_CTRL_RE_HF   9
`define PESC_CTRL_PIN     12
`define PESC_CTRL_RST     16'h0008

`define PESC_STAT2_RST    8'h00
`define PESC_EN2_RST      8'h00
`define PESC_FC_MAX       8'hFF
`define PESC_FC_HALF      8'h7F
`define PESC_RE_MAX       16'h00FF
`define PESC_RE_HALF      16'h007F

`endif

// ### core/pesc_pkg.sv
// Carrier types for the event status block
package pesc_pkg;

  typedef struct packed {
    logic eee_err;
    logic aneg_err;
    logic page_rx;
    logic lpbk_overflow_underflow;
    logic mdix_state;
    logic sleep_evt;
    logic polarity_chg;
    logic wake_packet;
    logic jabber;
  } pesc_evt_s;

  typedef struct packed {
    logic false_carrier;
    logic rx_dv;
    logic rx_err_sym;
    logic mii_loopback;
  } pesc_rx_s;

endpackage

// ### core/pesc_top.sv
// Second event status/enable register, receive counters and interrupt pin logic
//
// Design decision made here: the Wishbone slave port.
`timescale 1ns/100ps
`include "pesc_defines.svh"
// What this block does
// - Bit 15 latches on an energy-efficient Ethernet error; read-only, reset zero.
// - Bit 14 latches on an auto-negotiation error.
// - Bit 13 latches when a negotiation page is received.
// - Bit 12 latches on loopback FIFO overflow or underflow.
// - Bit 11 latches whenever the crossover state changes.
// - Bit 10 latches on a sleep mode event.
// - Bit 9 latches on polarity change or wake packet reception.
// - Bit 8 latches on jabber detection.
// - Enable bits 7 to 0, reset zero, gate status bits 15 to 8.
// - False carrier count is 8 bits in 7:0; upper bits read zero.
// - False carrier count holds at FFh.
// - False carrier count passing 7Fh raises an interrupt event.
// - Reading either counter register clears that counter.
// - 16-bit receive error count increments per invalid symbol during data valid.
// - No receive error counting in MII loopback.
// - Receive error count holds at its printed maximum FFh.
// - Receive error count passing 7Fh raises an interrupt event.
// - Event interrupts reach the pin only with the global enable set.
// - Pin is driven as interrupt only with output enable; else power-down input.
// - Polarity one idles high and pulls low on interrupt; zero inverts.

module pesc_top (
  input  wire logic                     CORE_CLK_IN,     // Core clock
  input  wire logic                     SYS_RST_IN,      // Sync reset, high
  input  wire logic                     CE_IN,           // Clock enable
  input  wire logic                     WB_CYC_IN,       // Bus cycle
  input  wire logic                     WB_STB_IN,       // Bus strobe
  input  wire logic                     WB_WE_IN,        // Write enable
  input  wire logic [`PESC_ADR_W-1:0]   WB_ADR_IN,       // Byte address
  input  wire logic [3:0]               WB_SEL_IN,       // Byte lanes
  input  wire logic [31:0]              WB_DAT_IN,       // Write data
  output logic      [31:0]              WB_DAT_OUT,      // Read data
  output logic                          WB_ACK_OUT,      // Acknowledge
  input  wire pesc_pkg::pesc_evt_s      EVENTS_IN,       // Core events
  input  wire pesc_pkg::pesc_rx_s       RX_IN,           // Receive path status
  input  wire logic                     IRQ_PIN_IN,      // Pin level seen
  output logic                          IRQ_PIN_OUT,     // Pin drive value
  output logic                          IRQ_PIN_OE_OUT,  // Pin drive enable
  output logic                          POWER_DOWN_OUT   // Power-down request
);

  logic [7:0]            stat2;
  logic [7:0]            en2;
  logic [7:0]            next_stat2;
  logic [7:0]            evt_vec;
  logic [7:0]            pend2;
  logic [7:0]            fc_cnt;
  logic [7:0]            next_fc;
  logic [15:0]           re_cnt;
  logic [15:0]           next_re;
  logic                  out_en;
  logic                  int_en;
  logic                  test_int;
  logic                  int_pol;
  logic                  fc_hf_en;
  logic                  re_hf_en;
  logic                  fc_hf;
  logic                  re_hf;
  logic                  pin_meta;
  logic                  pin_sync;
  logic                  mdix_prev;
  logic                  mdix_primed;
  logic                  xover_chg;
  logic                  wb_req;
  logic                  wb_rd;
  logic                  wb_wr;
  logic [`PESC_IDX_W-1:0] word_idx;
  logic                  hit_ctrl;
  logic                  hit_stat2;
  logic                  hit_fc;
  logic                  hit_re;
  logic                  rd_ctrl;
  logic                  rd_stat2;
  logic                  rd_fc;
  logic                  rd_re;
  logic                  fc_inc;
  logic                  re_evt;
  logic                  re_inc;
  logic                  fc_half_evt;
  logic                  re_half_evt;
  logic                  pend_any;
  logic                  irq_req;
  logic [15:0]           ctrl_view;
  logic [15:0]           rd_mux;

  // Reset image held as a constant so single fields can be picked from it
  localparam logic [15:0] ctrl_rst = `PESC_CTRL_RST;

  // Bus decode; a cycle is taken once, the ack flop blocks a repeat
  assign wb_req    = WB_CYC_IN & WB_STB_IN & ~WB_ACK_OUT;
  assign wb_rd     = wb_req & ~WB_WE_IN;
  assign wb_wr     = wb_req & WB_WE_IN;
  assign word_idx  = WB_ADR_IN[`PESC_ADR_W-1:2];
  assign hit_ctrl  = (word_idx == `PESC_IDX_CTRL);
  assign hit_stat2 = (word_idx == `PESC_IDX_STAT2);
  assign hit_fc    = (word_idx == `PESC_IDX_FCC);
  assign hit_re    = (word_idx == `PESC_IDX_REC);
  assign rd_ctrl   = wb_rd & hit_ctrl;
  assign rd_stat2  = wb_rd & hit_stat2;
  assign rd_fc     = wb_rd & hit_fc;
  assign rd_re     = wb_rd & hit_re;

  // Crossover change is seen only after a first sample, so reset gives no false event
  assign xover_chg = mdix_primed & (EVENTS_IN.mdix_state != mdix_prev);

  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      mdix_prev   <= 1'b0;
      mdix_primed <= 1'b0;
    end else if (CE_IN) begin
      mdix_prev   <= EVENTS_IN.mdix_state;
      mdix_primed <= 1'b1;
    end
  end

  assign evt_vec[7] = EVENTS_IN.eee_err;
  assign evt_vec[6] = EVENTS_IN.aneg_err;
  assign evt_vec[5] = EVENTS_IN.page_rx;
  assign evt_vec[4] = EVENTS_IN.lpbk_overflow_underflow;
  assign evt_vec[3] = xover_chg;
  assign evt_vec[2] = EVENTS_IN.sleep_evt;
  assign evt_vec[1] = EVENTS_IN.polarity_chg | EVENTS_IN.wake_packet;
  assign evt_vec[0] = EVENTS_IN.jabber;

  // A new event in the read cycle survives the clear
  for (genvar i = 0; i < 8; i++) begin : g_stat
    assign next_stat2[i] = evt_vec[i] | (stat2[i] & ~rd_stat2);
    assign pend2[i]      = stat2[i] & en2[i];
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      stat2 <= `PESC_STAT2_RST;
    end else if (CE_IN) begin
      stat2 <= next_stat2;
    end
  end

  // Only the enable half is writable; status bits ignore writes
  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      en2 <= `PESC_EN2_RST;
    end else if (CE_IN && wb_wr && hit_stat2 && WB_SEL_IN[0]) begin
      en2 <= WB_DAT_IN[7:0];
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      out_en   <= ctrl_rst[`PESC_CTRL_OUT_EN];
      int_en   <= ctrl_rst[`PESC_CTRL_INT_EN];
      test_int <= ctrl_rst[`PESC_CTRL_TEST];
      int_pol  <= ctrl_rst[`PESC_CTRL_POL];
      fc_hf_en <= ctrl_rst[`PESC_CTRL_FC_EN];
      re_hf_en <= ctrl_rst[`PESC_CTRL_RE_EN];
    end else if (CE_IN && wb_wr && hit_ctrl && WB_SEL_IN[0]) begin
      out_en   <= WB_DAT_IN[`PESC_CTRL_OUT_EN];
      int_en   <= WB_DAT_IN[`PESC_CTRL_INT_EN];
      test_int <= WB_DAT_IN[`PESC_CTRL_TEST];
      int_pol  <= WB_DAT_IN[`PESC_CTRL_POL];
      fc_hf_en <= WB_DAT_IN[`PESC_CTRL_FC_EN];
      re_hf_en <= WB_DAT_IN[`PESC_CTRL_RE_EN];
    end
  end

  // False carrier counter: saturates, cleared by its own read
  assign fc_inc      = RX_IN.false_carrier & (fc_cnt != `PESC_FC_MAX);
  assign fc_half_evt = fc_inc & (fc_cnt == `PESC_FC_HALF);

  always_comb begin
    if (rd_fc) begin
      next_fc = {7'h00, RX_IN.false_carrier};
    end else if (fc_inc) begin
      next_fc = fc_cnt + 8'h01;
    end else begin
      next_fc = fc_cnt;
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      fc_cnt <= 8'h00;
    end else if (CE_IN) begin
      fc_cnt <= next_fc;
    end
  end

  // Receive errors count only with data valid and outside MII loopback
  assign re_evt      = RX_IN.rx_dv & RX_IN.rx_err_sym & ~RX_IN.mii_loopback;
  assign re_inc      = re_evt & (re_cnt != `PESC_RE_MAX);
  assign re_half_evt = re_inc & (re_cnt == `PESC_RE_HALF);

  always_comb begin
    if (rd_re) begin
      next_re = {15'h0000, re_evt};
    end else if (re_inc) begin
      next_re = re_cnt + 16'h0001;
    end else begin
      next_re = re_cnt;
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      re_cnt <= 16'h0000;
    end else if (CE_IN) begin
      re_cnt <= next_re;
    end
  end

  // Half-full flags live in the control register and clear when it is read
  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      fc_hf <= 1'b0;
      re_hf <= 1'b0;
    end else if (CE_IN) begin
      fc_hf <= fc_half_evt | (fc_hf & ~rd_ctrl);
      re_hf <= re_half_evt | (re_hf & ~rd_ctrl);
    end
  end

  // Pin comes from outside the clock domain
  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      pin_meta <= 1'b1;
      pin_sync <= 1'b1;
    end else if (CE_IN) begin
      pin_meta <= IRQ_PIN_IN;
      pin_sync <= pin_meta;
    end
  end

  assign pend_any = (|pend2) | (fc_hf & fc_hf_en) | (re_hf & re_hf_en);
  // Test interrupt bypasses the global enable so the pin path can be checked alone
  assign irq_req  = (int_en & pend_any) | test_int;

  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      IRQ_PIN_OUT    <= 1'b1;
      IRQ_PIN_OE_OUT <= 1'b0;
    end else if (CE_IN) begin
      IRQ_PIN_OUT    <= int_pol ? ~irq_req : irq_req;
      IRQ_PIN_OE_OUT <= out_en;
    end
  end

  // Pin is active low as a power-down input, and only sensed while not driven
  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      POWER_DOWN_OUT <= 1'b0;
    end else if (CE_IN) begin
      POWER_DOWN_OUT <= ~out_en & ~pin_sync;
    end
  end

  always_comb begin
    ctrl_view                    = 16'h0000;
    ctrl_view[`PESC_CTRL_OUT_EN] = out_en;
    ctrl_view[`PESC_CTRL_INT_EN] = int_en;
    ctrl_view[`PESC_CTRL_TEST]   = test_int;
    ctrl_view[`PESC_CTRL_POL]    = int_pol;
    ctrl_view[`PESC_CTRL_FC_EN]  = fc_hf_en;
    ctrl_view[`PESC_CTRL_RE_EN]  = re_hf_en;
    ctrl_view[`PESC_CTRL_FC_HF]  = fc_hf;
    ctrl_view[`PESC_CTRL_RE_HF]  = re_hf;
    ctrl_view[`PESC_CTRL_PIN]    = pin_sync;
  end

  // Unmapped words read as zero and still acknowledge
  always_comb begin
    if (hit_ctrl) begin
      rd_mux = ctrl_view;
    end else if (hit_stat2) begin
      rd_mux = {stat2, en2};
    end else if (hit_fc) begin
      rd_mux = {8'h00, fc_cnt};
    end else if (hit_re) begin
      rd_mux = re_cnt;
    end else begin
      rd_mux = 16'h0000;
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      WB_ACK_OUT <= 1'b0;
      WB_DAT_OUT <= 32'h0000_0000;
    end else if (CE_IN) begin
      WB_ACK_OUT <= wb_req;
      if (wb_rd) begin
        WB_DAT_OUT <= {16'h0000, rd_mux};
      end
    end
  end

endmodule // pesc_top

// ### verif/pesc_host_model.sv
// Host side of the shared pin: pull-up that the host may pull low
`timescale 1ns/100ps
module pesc_host_model (
  input  wire logic dev_oe_in,  // Device drives
  input  wire logic dev_out_in, // Drive value
  input  wire logic host_pd_in, // Host pulls low
  output logic      pin_out     // Wire level
);
  // Released pin rests at the pull-up level, never a stale value
  assign pin_out = dev_oe_in ? dev_out_in : !host_pd_in;
endmodule // pesc_host_model

// ### verif/pesc_top_monitor.sv
// Port checker for the event status block
`timescale 1ns/100ps
`include "pesc_defines.svh"
module pesc_top_monitor (
  input wire logic                   CORE_CLK_IN,   // Clock
  input wire logic                   SYS_RST_IN,    // Reset
  input wire logic                   CE_IN,         // Enable
  input wire logic                   WB_CYC_IN,     // Cycle
  input wire logic                   WB_STB_IN,     // Strobe
  input wire logic                   WB_WE_IN,      // Write
  input wire logic [`PESC_ADR_W-1:0] WB_ADR_IN,     // Address
  input wire logic [3:0]             WB_SEL_IN,     // Lanes
  input wire logic [31:0]            WB_DAT_IN,     // Wdata
  input wire logic [31:0]            WB_DAT_OUT,    // Rdata
  input wire logic                   WB_ACK_OUT,    // Ack
  input wire pesc_pkg::pesc_evt_s    EVENTS_IN,     // Events
  input wire pesc_pkg::pesc_rx_s     RX_IN,         // Receive
  input wire logic                   IRQ_PIN_OE_OUT // Pin enable
);
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (SYS_RST_IN || !CE_IN);
  logic req, rd_st, rd_fc, wr_ct;
  assign req = WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
  assign rd_st = req && !WB_WE_IN && WB_ADR_IN[7:2] == `PESC_IDX_STAT2;
  assign rd_fc = req && !WB_WE_IN && WB_ADR_IN[7:2] == `PESC_IDX_FCC;
  assign wr_ct = req && WB_WE_IN && WB_SEL_IN[0] && WB_ADR_IN[7:2] == `PESC_IDX_CTRL;
  // Crossover is a level, so only its change counts as an event
  sequence quiet;
    (EVENTS_IN & 9'h1EF) == 9'h000 && $stable(EVENTS_IN.mdix_state);
  endsequence
  sequence fc_twice;
    (rd_fc && !RX_IN.false_carrier) ##1 !RX_IN.false_carrier [*2] ##1 rd_fc;
  endsequence
  sequence st_twice;
    rd_st ##0 quiet ##1 quiet [*2] ##1 rd_st;
  endsequence
  chk_ack_taken: assert property (req |=> WB_ACK_OUT) else $error("no ack");
  chk_ack_single: assert property (WB_ACK_OUT |=> !WB_ACK_OUT) else $error("long ack");
  chk_oe_follow: assert property (wr_ct |=> ##1 IRQ_PIN_OE_OUT == $past(WB_DAT_IN[0], 2)) else $error("oe");
  chk_fc_upper: assert property (rd_fc |=> WB_DAT_OUT[31:8] == 24'h000000) else $error("fc upper");
  chk_fc_clear: assert property (fc_twice |=> WB_DAT_OUT[7:0] == 8'h00) else $error("fc not cleared");
  chk_stat_clear: assert property (st_twice |=> WB_DAT_OUT[15:8] == 8'h00) else $error("status kept");
  chk_eee_latch: assert property (EVENTS_IN.eee_err ##1 !rd_st ##1 rd_st |=> WB_DAT_OUT[15]) else $error("eee");
  chk_pw_latch: assert property ((EVENTS_IN.polarity_chg || EVENTS_IN.wake_packet) ##1 !rd_st ##1 rd_st
    |=> WB_DAT_OUT[9]) else $error("pol or wake");
endmodule // pesc_top_monitor
bind pesc_top pesc_top_monitor u_mon (.*);

// ### verif/testbench.sv
// Self-checking bench for the event status block
`timescale 1ns/100ps
module testbench;
  logic clk, rst, cyc, stb, we, ack, pd, pin, pout, poe, pdn, ce;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat, dout, q;
  logic [15:0] cfg [3] = '{16'h000B, 16'h0009, 16'h0003};
  pesc_pkg::pesc_evt_s ev;
  pesc_pkg::pesc_rx_s rx;
  int n_mismatch, n_checks, seed, m_fc, m_re, m_en, r;
  pesc_top u_dut (.CORE_CLK_IN(clk), .SYS_RST_IN(rst), .CE_IN(ce), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
    .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(dat), .WB_DAT_OUT(dout), .WB_ACK_OUT(ack),
    .EVENTS_IN(ev), .RX_IN(rx), .IRQ_PIN_IN(pin), .IRQ_PIN_OUT(pout), .IRQ_PIN_OE_OUT(poe), .POWER_DOWN_OUT(pdn));
  pesc_host_model u_host (.dev_oe_in(poe), .dev_out_in(pout), .host_pd_in(pd), .pin_out(pin));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic wrap_up;
    if (n_mismatch == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic cmp_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic cmp_bit(input string nm, input logic e, input logic g);
    cmp_reg(nm, {31'h0, e}, {31'h0, g});
  endtask
  // Ack is sampled at the edge, so read data is taken with it
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = dout;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    wb(1'b0, a, 32'h0);
    cmp_reg(nm, e, q);
  endtask
  task automatic rx_run(input logic [3:0] v, input int n);
    @(posedge clk);
    rx <= v;
    repeat (n) @(posedge clk);
    rx <= 4'h0;
    if (v[3]) m_fc = (m_fc + n > 255) ? 255 : m_fc + n;
    if (v[2:0] == 3'b110) m_re = (m_re + n > 255) ? 255 : m_re + n;
  endtask
  task automatic ev_pulse(input int i);
    @(posedge clk);
    ev[i] <= ~ev[i];
    if (i != 4) begin
      @(posedge clk);
      ev[i] <= ~ev[i];
    end
  endtask
  initial begin
    {rst, cyc, stb, we, pd, ce} = 6'b100001;
    adr = 8'h00;
    sel = 4'hF;
    dat = 32'h0;
    ev = '0;
    rx = '0;
    {n_mismatch, n_checks, m_fc, m_re} = '0;
    seed = 91;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(8'h44, 32'h0000_1008, "ctrl");
    for (int a = 8'h4C; a <= 8'h54; a += 4) rd(8'(a), 32'h0, "reset");
    wb(1'b1, 8'h00, 32'hFFFF_FFFF);
    rd(8'h00, 32'h0, "unmapped");
    m_en = $random(seed) & 8'hFF;
    wb(1'b1, 8'h4C, 32'hFFFF_FF00 | 32'(m_en));
    wb(1'b1, 8'h50, 32'h0000_00FF);
    sel <= 4'hE;
    wb(1'b1, 8'h4C, ~32'(m_en));
    sel <= 4'hF;
    rd(8'h4C, 32'(m_en), "enables");
    rd(8'h50, 32'h0, "fc_ro");
    for (int i = 0; i < 9; i++) begin
      ev_pulse(i);
      r = (i < 2) ? i + 8 : i + 7;
      rd(8'h4C, 32'(m_en) | (32'h1 << r), "status");
      rd(8'h4C, 32'(m_en), "cleared");
    end
    wb(1'b1, 8'h4C, 32'h1);
    for (int k = 0; k < 3; k++) begin
      wb(1'b1, 8'h44, 32'(cfg[k]));
      ev_pulse(0);
      repeat (3) @(posedge clk);
      cmp_bit("irq", k != 0, pout);
      cmp_bit("oe", 1'b1, poe);
      wb(1'b0, 8'h4C, 32'h0);
      repeat (3) @(posedge clk);
      cmp_bit("idle", k != 2, pout);
    end
    for (int k = 0; k < 2; k++) begin
      wb(1'b1, 8'h44, 32'(16'h1B + 16 * k));
      rx_run(k ? 4'h6 : 4'h8, 127);
      repeat (3) @(posedge clk);
      cmp_bit("below_half", 1'b1, pout);
      rx_run(k ? 4'h6 : 4'h8, 201);
      cmp_bit("past_half", 1'b0, pout);
      rd(8'(8'h50 + 4 * k), 32'(k ? m_re : m_fc), "count_max");
      rd(8'(8'h50 + 4 * k), 32'h0, "count_clr");
      {m_fc, m_re} = '0;
      rd(8'h44, 32'(16'h1B + 16 * k) | (32'h1 << (8 + k)), "half_flag");
      repeat (3) @(posedge clk);
      cmp_bit("flag_clr", 1'b1, pout);
    end
    rx_run(4'h2, 5);
    rx_run(4'h7, 5);
    r = ($random(seed) & 63) + 1;
    rx_run(4'hE, r);
    rd(8'h54, 32'(m_re), "rx_err");
    rd(8'h50, 32'(m_fc), "fc_cnt");
    wb(1'b1, 8'h44, 32'h8);
    pd <= 1'b1;
    repeat (6) @(posedge clk);
    cmp_bit("pdown", 1'b1, pdn);
    pd <= 1'b0;
    repeat (6) @(posedge clk);
    cmp_bit("pup", 1'b0, pdn);
    // An event while frozen must leave no trace
    ce <= 1'b0;
    ev_pulse(0);
    ce <= 1'b1;
    rd(8'h4C, 32'h1, "frozen");
    wrap_up;
  end
  // Run is about a thousand cycles; this bound is far beyond that
  initial begin
    #800000;
    n_mismatch++;
    wrap_up;
  end
endmodule // testbench
